//--- tkrr_pkg.sv
// Constants shared by the touch key result and configuration block.
// Assumes a single 10 MHz system clock and a byte-wide register port.
package tkrr_pkg;
	localparam int unsigned NUM_KEYS = 16;
	localparam logic [7:0] ADDR_OP_MODE = 8'h0b;
	localparam logic [7:0] ADDR_CONFIRM = 8'h0f;
	localparam logic [7:0] ADDR_GROUP_FIRST = 8'h1b;
	localparam logic [7:0] ADDR_GROUP_LAST = 8'h1e;
	localparam logic [7:0] ADDR_ENABLE_LOW = 8'h1f;
	localparam logic [7:0] ADDR_ENABLE_HIGH = 8'h20;
	localparam logic [7:0] ADDR_NOISE_FIRST = 8'h21;
	localparam logic [7:0] ADDR_NOISE_LAST = 8'h30;
	localparam logic [7:0] ADDR_MASK_LOW = 8'h31;
	localparam logic [7:0] ADDR_MASK_HIGH = 8'h32;
	localparam logic [7:0] ADDR_PRESS_FIRST = 8'h33;
	localparam logic [7:0] ADDR_PRESS_LAST = 8'h42;
	localparam logic [7:0] ADDR_RAW_FIRST = 8'h43;
	localparam logic [7:0] ADDR_RAW_LAST = 8'h62;
	localparam logic [7:0] ADDR_FAULT = 8'h63;
	localparam logic [7:0] ADDR_POSITION = 8'h64;
	localparam logic [7:0] ADDR_FLAGS_HIGH = 8'h65;
	localparam logic [7:0] ADDR_FLAGS_LOW = 8'h66;
	localparam logic [7:0] RST_ENABLE = 8'hff;
	localparam logic [7:0] RST_MASK = 8'hff;
	localparam logic [7:0] RST_NOISE = 8'h20;
	localparam logic [7:0] RST_PRESS = 8'h30;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] FAULT_POWER_ON = 8'h02;
	localparam logic [7:0] FAULT_CLEAR_WDOG = 8'h01;
	localparam logic [7:0] FAULT_NONE = 8'h00;
	localparam int unsigned CONFIRM_W = 3;
	localparam logic [7:0] SLIDER_STEP = 8'h10;
	typedef enum logic [1:0] {
		TKRR_GROUP_FREE = 2'b00,
		TKRR_GROUP_EXCL_A = 2'b01,
		TKRR_GROUP_EXCL_B = 2'b10,
		TKRR_GROUP_SLIDER = 2'b11
	} tkrr_group_type;
endpackage

//--- tkrr_key_debounce.sv
// One key's touch qualifier: consecutive-reading confirmation plus
// release hysteresis against the noise limit. Fed once per reading.
`timescale 1ns/10ps
module tkrr_key_debounce
	import tkrr_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic sample_i,
	input wire logic [15:0] delta_i,
	input wire logic [7:0] press_limit_i,
	input wire logic [7:0] noise_limit_i,
	input wire logic [CONFIRM_W-1:0] confirm_i,
	output logic touched_o
);
	logic [CONFIRM_W-1:0] count;
	logic [CONFIRM_W-1:0] next_count;
	logic touched;
	logic next_touched;
	logic crossing;
	logic quiet;

	assign crossing = delta_i > {8'h00, press_limit_i};
	assign quiet = delta_i < {8'h00, noise_limit_i};
	assign touched_o = touched;

	always_comb begin
		next_count = count;
		next_touched = touched;
		if (!enable_i) begin
			next_count = '0;
			next_touched = 1'b0;
		end else if (sample_i) begin
			if (crossing) begin
				if (count >= confirm_i) begin
					next_touched = 1'b1;
				end else begin
					next_count = count + 1'b1;
				end
			end else begin
				next_count = '0;
				if (quiet || !touched) begin
					next_touched = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			count <= '0;
			touched <= 1'b0;
		end else begin
			count <= next_count;
			touched <= next_touched;
		end
	end
endmodule

//--- tkrr_group_resolve.sv
// Applies the per-group reporting policy to qualified touches and
// derives the slider coordinate. Purely combinational.
`timescale 1ns/10ps
module tkrr_group_resolve
	import tkrr_pkg::*;
(
	input wire logic [NUM_KEYS-1:0] qualified_i,
	input wire logic [2*NUM_KEYS-1:0] group_i,
	output logic [NUM_KEYS-1:0] reported_o,
	output logic slider_touch_o,
	output logic [7:0] slider_pos_o
);
	always_comb begin
		logic taken_a;
		logic taken_b;
		logic [7:0] rank;
		tkrr_group_type grp;
		taken_a = 1'b0;
		taken_b = 1'b0;
		rank = 8'h00;
		grp = TKRR_GROUP_FREE;
		reported_o = '0;
		slider_touch_o = 1'b0;
		slider_pos_o = 8'h00;
		for (int k = 0; k < NUM_KEYS; k++) begin
			grp = tkrr_group_type'(group_i[2*k +: 2]);
			unique case (grp)
				TKRR_GROUP_FREE: begin
					reported_o[k] = qualified_i[k];
				end
				TKRR_GROUP_EXCL_A: begin
					reported_o[k] = qualified_i[k] && !taken_a;
					taken_a = taken_a || qualified_i[k];
				end
				TKRR_GROUP_EXCL_B: begin
					reported_o[k] = qualified_i[k] && !taken_b;
					taken_b = taken_b || qualified_i[k];
				end
				TKRR_GROUP_SLIDER: begin
					reported_o[k] = qualified_i[k];
					if (qualified_i[k] && !slider_touch_o) begin
						slider_touch_o = 1'b1;
						slider_pos_o = 8'(rank * SLIDER_STEP);
					end
					rank = rank + 8'h01;
				end
			endcase
		end
	end
endmodule

//--- tkrr_touch_key_regs.sv
// Top of the touch key result and configuration block: register file,
// measurement scan order, raw data store and data ready request pin.
// Assumes the serial front end presents byte accesses on sys_clk_i and
// the analog engine answers each request with one done pulse.
`timescale 1ns/10ps
module tkrr_touch_key_regs
	import tkrr_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic master_clear_reset_n_i,
	input wire logic watchdog_event_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic meas_req_o,
	output logic [3:0] meas_key_o,
	input wire logic meas_done_i,
	input wire logic [15:0] meas_raw_i,
	input wire logic [15:0] meas_delta_i,
	output logic ready_request_low_o
);
	logic master_clear_reset_meta;
	logic master_clear_reset_sync;
	logic core_rst;

	logic [7:0] op_mode;
	logic [7:0] next_op_mode;
	logic [CONFIRM_W-1:0] confirm;
	logic [CONFIRM_W-1:0] next_confirm;
	logic [2*NUM_KEYS-1:0] group_codes;
	logic [2*NUM_KEYS-1:0] next_group_codes;
	logic [NUM_KEYS-1:0] key_enable;
	logic [NUM_KEYS-1:0] next_key_enable;
	logic [NUM_KEYS-1:0] request_mask;
	logic [NUM_KEYS-1:0] next_request_mask;
	logic [7:0] noise_limit [NUM_KEYS];
	logic [7:0] next_noise_limit [NUM_KEYS];
	logic [7:0] press_limit [NUM_KEYS];
	logic [7:0] next_press_limit [NUM_KEYS];
	logic [15:0] raw_data [NUM_KEYS];
	logic [15:0] next_raw_data [NUM_KEYS];
	logic [7:0] fault_code_field;
	logic [7:0] next_fault_code_field;

	logic [3:0] scan_key;
	logic [3:0] next_scan_key;
	logic [NUM_KEYS-1:0] qualified;
	logic [NUM_KEYS-1:0] reported;
	logic [NUM_KEYS-1:0] reported_prev;
	logic slider_touch;
	logic [7:0] slider_pos_now;
	logic [7:0] slider_position;
	logic [7:0] next_slider_position;
	logic data_ready_request;
	logic next_data_ready_request;
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	logic change_event;
	logic flags_read;

	// low pin holds core in reset
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			master_clear_reset_meta <= 1'b1;
			master_clear_reset_sync <= 1'b1;
		end else begin
			master_clear_reset_meta <= master_clear_reset_n_i;
			master_clear_reset_sync <= master_clear_reset_meta;
		end
	end
	assign core_rst = rst_i || !master_clear_reset_sync;

	// Register writes
	always_comb begin
		logic [7:0] idx;
		idx = 8'h00;
		next_op_mode = op_mode;
		next_confirm = confirm;
		next_group_codes = group_codes;
		next_key_enable = key_enable;
		next_request_mask = request_mask;
		next_noise_limit = noise_limit;
		next_press_limit = press_limit;
		if (reg_wr_i) begin
			if (reg_addr_i == ADDR_OP_MODE) begin
				next_op_mode = reg_wdata_i;
			end
			if (reg_addr_i == ADDR_CONFIRM) begin
				next_confirm = reg_wdata_i[CONFIRM_W-1:0];
			end
			if (reg_addr_i >= ADDR_GROUP_FIRST && reg_addr_i <= ADDR_GROUP_LAST) begin
				idx = reg_addr_i - ADDR_GROUP_FIRST;
				next_group_codes[8*idx[1:0] +: 8] = reg_wdata_i;
			end
			if (reg_addr_i == ADDR_ENABLE_LOW) begin
				next_key_enable[7:0] = reg_wdata_i;
			end
			if (reg_addr_i == ADDR_ENABLE_HIGH) begin
				next_key_enable[15:8] = reg_wdata_i;
			end
			if (reg_addr_i == ADDR_MASK_LOW) begin
				next_request_mask[7:0] = reg_wdata_i;
			end
			if (reg_addr_i == ADDR_MASK_HIGH) begin
				next_request_mask[15:8] = reg_wdata_i;
			end
			if (reg_addr_i >= ADDR_NOISE_FIRST && reg_addr_i <= ADDR_NOISE_LAST) begin
				idx = reg_addr_i - ADDR_NOISE_FIRST;
				next_noise_limit[idx[3:0]] = reg_wdata_i;
			end
			if (reg_addr_i >= ADDR_PRESS_FIRST && reg_addr_i <= ADDR_PRESS_LAST) begin
				idx = reg_addr_i - ADDR_PRESS_FIRST;
				next_press_limit[idx[3:0]] = reg_wdata_i;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (core_rst) begin
			op_mode <= RST_ZERO;
			confirm <= '0;
			group_codes <= '0;
			key_enable <= {RST_ENABLE, RST_ENABLE};
			request_mask <= {RST_MASK, RST_MASK};
			for (int k = 0; k < NUM_KEYS; k++) begin
				noise_limit[k] <= RST_NOISE;
				press_limit[k] <= RST_PRESS;
			end
		end else begin
			op_mode <= next_op_mode;
			confirm <= next_confirm;
			group_codes <= next_group_codes;
			key_enable <= next_key_enable;
			request_mask <= next_request_mask;
			noise_limit <= next_noise_limit;
			press_limit <= next_press_limit;
		end
	end

	// Fault code: survives a pin reset so the cause stays visible
	always_comb begin
		next_fault_code_field = fault_code_field;
		if (reg_wr_i && reg_addr_i == ADDR_FAULT) begin
			next_fault_code_field = FAULT_NONE;
		end
		if (!master_clear_reset_sync || watchdog_event_i) begin
			next_fault_code_field = FAULT_CLEAR_WDOG;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			fault_code_field <= FAULT_POWER_ON;
		end else begin
			fault_code_field <= next_fault_code_field;
		end
	end

	// Scan order and raw data capture
	always_comb begin
		logic found;
		logic [3:0] cand;
		found = 1'b0;
		cand = scan_key;
		next_scan_key = scan_key;
		next_raw_data = raw_data;
		if (meas_done_i && meas_req_o) begin
			next_raw_data[scan_key] = meas_raw_i;
		end
		if ((meas_done_i && meas_req_o) || !key_enable[scan_key]) begin
			for (int s = 1; s <= NUM_KEYS; s++) begin
				cand = 4'(scan_key + s);
				if (!found && key_enable[cand]) begin
					found = 1'b1;
					next_scan_key = cand;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (core_rst) begin
			scan_key <= 4'h0;
			for (int k = 0; k < NUM_KEYS; k++) begin
				raw_data[k] <= 16'h0000;
			end
		end else begin
			scan_key <= next_scan_key;
			raw_data <= next_raw_data;
		end
	end

	// no request while current key disabled
	assign meas_req_o = key_enable[scan_key];
	assign meas_key_o = scan_key;

	genvar g;
	generate
		for (g = 0; g < NUM_KEYS; g++) begin : gen_key
			tkrr_key_debounce u_debounce (
				.sys_clk_i(sys_clk_i),
				.rst_i(core_rst),
				.enable_i(key_enable[g]),
				.sample_i(meas_done_i && meas_req_o && scan_key == 4'(g)),
				.delta_i(meas_delta_i),
				.press_limit_i(press_limit[g]),
				.noise_limit_i(noise_limit[g]),
				.confirm_i(confirm),
				.touched_o(qualified[g])
			);
		end
	endgenerate

	tkrr_group_resolve u_resolve (
		.qualified_i(qualified),
		.group_i(group_codes),
		.reported_o(reported),
		.slider_touch_o(slider_touch),
		.slider_pos_o(slider_pos_now)
	);

	assign change_event = |((reported ^ reported_prev) & request_mask);
	assign flags_read = reg_rd_i &&
		(reg_addr_i == ADDR_FLAGS_HIGH || reg_addr_i == ADDR_FLAGS_LOW);

	always_comb begin
		next_slider_position = slider_position;
		if (slider_touch) begin
			next_slider_position = slider_pos_now;
		end
		next_data_ready_request = data_ready_request;
		if (flags_read) begin
			next_data_ready_request = 1'b0;
		end
		if (change_event && op_mode == RST_ZERO) begin
			next_data_ready_request = 1'b1;
		end
		if (op_mode != RST_ZERO) begin
			next_data_ready_request = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (core_rst) begin
			reported_prev <= '0;
			slider_position <= RST_ZERO;
			data_ready_request <= 1'b0;
		end else begin
			reported_prev <= reported;
			slider_position <= next_slider_position;
			data_ready_request <= next_data_ready_request;
		end
	end

	assign ready_request_low_o = !data_ready_request;

	// Read data, registered one cycle after the strobe
	always_comb begin
		logic [7:0] idx;
		idx = 8'h00;
		next_rdata = rdata;
		if (reg_rd_i) begin
			next_rdata = 8'h00;
			if (reg_addr_i == ADDR_OP_MODE) begin
				next_rdata = op_mode;
			end
			if (reg_addr_i == ADDR_CONFIRM) begin
				next_rdata = {{(8-CONFIRM_W){1'b0}}, confirm};
			end
			if (reg_addr_i >= ADDR_GROUP_FIRST && reg_addr_i <= ADDR_GROUP_LAST) begin
				idx = reg_addr_i - ADDR_GROUP_FIRST;
				next_rdata = group_codes[8*idx[1:0] +: 8];
			end
			if (reg_addr_i == ADDR_ENABLE_LOW) begin
				next_rdata = key_enable[7:0];
			end
			if (reg_addr_i == ADDR_ENABLE_HIGH) begin
				next_rdata = key_enable[15:8];
			end
			if (reg_addr_i >= ADDR_NOISE_FIRST && reg_addr_i <= ADDR_NOISE_LAST) begin
				idx = reg_addr_i - ADDR_NOISE_FIRST;
				next_rdata = noise_limit[idx[3:0]];
			end
			if (reg_addr_i == ADDR_MASK_LOW) begin
				next_rdata = request_mask[7:0];
			end
			if (reg_addr_i == ADDR_MASK_HIGH) begin
				next_rdata = request_mask[15:8];
			end
			if (reg_addr_i >= ADDR_PRESS_FIRST && reg_addr_i <= ADDR_PRESS_LAST) begin
				idx = reg_addr_i - ADDR_PRESS_FIRST;
				next_rdata = press_limit[idx[3:0]];
			end
			if (reg_addr_i >= ADDR_RAW_FIRST && reg_addr_i <= ADDR_RAW_LAST) begin
				idx = reg_addr_i - ADDR_RAW_FIRST;
				next_rdata = idx[0] ? raw_data[idx[4:1]][7:0] : raw_data[idx[4:1]][15:8];
			end
			if (reg_addr_i == ADDR_FAULT) begin
				next_rdata = fault_code_field;
			end
			if (reg_addr_i == ADDR_POSITION) begin
				next_rdata = slider_position;
			end
			if (reg_addr_i == ADDR_FLAGS_HIGH) begin
				next_rdata = reported[15:8];
			end
			if (reg_addr_i == ADDR_FLAGS_LOW) begin
				next_rdata = reported[7:0];
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (core_rst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end
	assign reg_rdata_o = rdata;
endmodule

//--- tkrr_regs_checker.sv
// Assertion checker for the touch key register block, top ports only.
// Assumes one clock; helpers mirror host writes to enable, mask, mode and fault code.
`timescale 1ns/10ps
module tkrr_regs_checker
	import tkrr_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic master_clear_reset_n_i,
	input wire logic watchdog_event_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic meas_req_o,
	input wire logic [3:0] meas_key_o,
	input wire logic meas_done_i,
	input wire logic [15:0] meas_raw_i,
	input wire logic [15:0] meas_delta_i,
	input wire logic ready_request_low_o
);
	logic [15:0] en_m;
	logic [15:0] mask_m;
	logic op_nz;
	logic [7:0] fault_m;
	logic [2:0] hold;
	// Hold covers the pin synchroniser and core reset tail
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !master_clear_reset_n_i) begin
			en_m <= 16'hffff;
			mask_m <= 16'hffff;
			op_nz <= 1'b0;
			fault_m <= rst_i ? 8'h02 : 8'h01;
			hold <= rst_i ? 3'd0 : 3'd4;
		end else begin
			hold <= (hold != 3'd0) ? hold - 3'd1 : hold;
			if (reg_wr_i && reg_addr_i == 8'h1f) en_m[7:0] <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == 8'h20) en_m[15:8] <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == 8'h31) mask_m[7:0] <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == 8'h32) mask_m[15:8] <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == 8'h0b) op_nz <= (reg_wdata_i != 8'h00);
			if (watchdog_event_i) fault_m <= 8'h01;
			else if (reg_wr_i && reg_addr_i == 8'h63) fault_m <= 8'h00;
		end
	end
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i || hold != 3'd0);
	property p_reset_vals;
		$fell(rst_i) |-> ready_request_low_o && meas_key_o == 4'd0;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("pin or key wrong after reset");
	property p_key_hold;
		meas_req_o && !meas_done_i |=> $stable(meas_key_o);
	endproperty
	a_key_hold: assert property (p_key_hold)
		else $error("key moved without a reading");
	property p_key_next;
		meas_req_o && meas_done_i && en_m == 16'hffff |=> meas_key_o == $past(meas_key_o) + 4'd1;
	endproperty
	a_key_next: assert property (p_key_next)
		else $error("scan did not step to next key");
	property p_skip_off;
		meas_req_o == en_m[meas_key_o];
	endproperty
	a_skip_off: assert property (p_skip_off)
		else $error("request does not follow key enable");
	property p_skip_move;
		!meas_req_o && en_m != 16'h0000 |=> meas_key_o != $past(meas_key_o);
	endproperty
	a_skip_move: assert property (p_skip_move)
		else $error("disabled key not skipped");
	property p_rdata_hold;
		!reg_rd_i |=> $stable(reg_rdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed without a read");
	property p_unmapped;
		reg_rd_i && reg_addr_i > 8'h66 |=> reg_rdata_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_fault_read;
		reg_rd_i && reg_addr_i == 8'h63 |=> reg_rdata_o == $past(fault_m);
	endproperty
	a_fault_read: assert property (p_fault_read)
		else $error("fault code read wrong");
	property p_query_high;
		op_nz && $past(op_nz) |-> ready_request_low_o;
	endproperty
	a_query_high: assert property (p_query_high)
		else $error("request pin low in query mode");
	property p_mask_gate;
		// Request is set one edge before the pin falls, from mode and mask of then
		$fell(ready_request_low_o) |-> !$past(op_nz) && $past(mask_m) != 16'h0000;
	endproperty
	a_mask_gate: assert property (p_mask_gate)
		else $error("request raised with all changes masked");
endmodule

//--- tkrr_engine_model.sv
// Behavioural sensing engine: one done pulse per request, prompt or stalled.
// Assumes the bench supplies per-key signal levels; raw is level plus 1000h.
`timescale 1ns/10ps
module tkrr_engine_model (
	input wire logic sys_clk_i,
	input wire logic req_i,
	input wire logic [3:0] key_i,
	input wire logic [255:0] level_i,
	input wire logic slow_i,
	output logic done_o,
	output logic [15:0] raw_o,
	output logic [15:0] delta_o
);
	int gap;
	initial begin
		done_o = 1'b0;
		raw_o = 16'h0000;
		delta_o = 16'h0000;
		gap = 0;
	end
	always @(posedge sys_clk_i) begin
		#1;
		if (done_o) begin
			done_o = 1'b0;
			// Stale data must never look valid
			raw_o = ~raw_o;
			delta_o = ~delta_o;
			gap = slow_i ? 3 : 0;
		end else if (gap != 0) begin
			gap = gap - 1;
		end else if (req_i) begin
			done_o = 1'b1;
			raw_o = level_i[16*key_i+:16] + 16'h1000;
			delta_o = level_i[16*key_i+:16];
		end
	end
endmodule

//--- test_touch_key_result_registers.sv
// Self-checking bench for the touch key register block.
// Assumes byte register strobes taken on the edge and the engine model alongside.
`timescale 1ns/10ps
module test_touch_key_result_registers;
	import tkrr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic clear_n = 1'b1;
	logic wdog = 1'b0;
	logic [7:0] addr = 8'h00;
	logic wr_s = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic rd_s = 1'b0;
	logic [7:0] rdata;
	logic req;
	logic done;
	logic slow = 1'b0;
	logic pin_n;
	logic [3:0] key;
	logic [15:0] raw;
	logic [15:0] delta;
	logic [255:0] level = '0;
	logic [31:0] seed = 32'hbc143124;
	int n_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	tkrr_touch_key_regs i_dut (.sys_clk_i(clk), .rst_i(rst), .master_clear_reset_n_i(clear_n),
		.watchdog_event_i(wdog), .reg_addr_i(addr), .reg_wr_i(wr_s), .reg_wdata_i(wdata),
		.reg_rd_i(rd_s), .reg_rdata_o(rdata), .meas_req_o(req), .meas_key_o(key),
		.meas_done_i(done), .meas_raw_i(raw), .meas_delta_i(delta), .ready_request_low_o(pin_n));
	tkrr_engine_model i_eng (.sys_clk_i(clk), .req_i(req), .key_i(key), .level_i(level),
		.slow_i(slow), .done_o(done), .raw_o(raw), .delta_o(delta));
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic give_verdict();
		if (n_errors == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr_s = 1'b1;
		cyc(1);
		wr_s = 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		addr = a;
		rd_s = 1'b1;
		cyc(1);
		rd_s = 1'b0;
		d = rdata;
		cyc(1);
	endtask
	function automatic logic [7:0] exp_rst(input logic [7:0] a);
		if (a >= 8'h21 && a <= 8'h30) return 8'h20;
		if (a >= 8'h33 && a <= 8'h42) return 8'h30;
		if (a == 8'h1f || a == 8'h20 || a == 8'h31 || a == 8'h32) return 8'hff;
		return 8'h00;
	endfunction
	// Exclusive groups keep only their lowest touched key
	function automatic logic [15:0] exp_flags(input logic [15:0] t, input logic [31:0] g);
		logic [15:0] f;
		logic [3:0] taken;
		f = '0;
		taken = '0;
		for (int k = 0; k < 16; k++) begin
			f[k] = t[k] && !((g[2*k+:2] == 2'b01 || g[2*k+:2] == 2'b10) && taken[g[2*k+:2]]);
			if (t[k]) taken[g[2*k+:2]] = 1'b1;
		end
		return f;
	endfunction
	function automatic logic [7:0] exp_pos(input logic [15:0] t, input logic [31:0] g);
		logic [7:0] r;
		r = 8'h00;
		for (int k = 0; k < 16; k++) begin
			if (g[2*k+:2] == 2'b11) begin
				if (t[k]) return r;
				r = r + 8'h10;
			end
		end
		return 8'h00;
	endfunction
	initial begin
		logic [7:0] d;
		logic [7:0] e;
		logic [7:0] op;
		logic [15:0] t;
		logic [15:0] t_prev;
		logic [15:0] en;
		logic [15:0] mask;
		logic [15:0] old;
		logic [15:0] f;
		logic [31:0] g;
		logic [31:0] x;
		logic [15:0] sl;
		t_prev = 16'h0000;
		cyc(3);
		rst = 1'b0;
		for (int a = 8'h0b; a <= 8'h42; a++) begin
			rd(8'(a), d);
			check(16'(d), 16'(exp_rst(8'(a))));
		end
		rd(8'h63, d);
		check(16'(d), 16'h0002);
		for (int i = 0; i < 24; i++) begin
			x = rnd();
			e = 8'h21 + 8'(x[15:0] % 16'd34);
			wr(e, x[31:24]);
			rd(e, d);
			check(16'(d), 16'(x[31:24]));
		end
		for (int k = 0; k < 16; k++) begin
			wr(8'h21 + 8'(k), 8'h20);
			wr(8'h33 + 8'(k), 8'h30);
		end
		wr(8'h43, 8'haa);
		rd(8'h43, d);
		check(16'(d), 16'h0010);
		wr(8'h70, 8'h55);
		rd(8'h70, d);
		check(16'(d), 16'h0000);
		wr(8'h63, 8'h5a);
		rd(8'h63, d);
		check(16'(d), 16'h0000);
		wdog = 1'b1;
		wr(8'h63, 8'h00);
		wdog = 1'b0;
		rd(8'h63, d);
		check(16'(d), 16'h0001);
		for (int r = 0; r < 10; r++) begin
			g = rnd();
			en = (r % 2 == 1) ? 16'(rnd() | 32'h1) : 16'hffff;
			mask = (r == 2) ? 16'h0000 : 16'(rnd());
			op = (r % 4 == 3) ? 8'(rnd() | 32'h1) : 8'h00;
			x = rnd();
			t = x[15:0];
			slow = x[16];
			for (int i = 0; i < 4; i++) wr(8'h1b + 8'(i), g[8*i+:8]);
			wr(8'h1f, en[7:0]);
			wr(8'h20, en[15:8]);
			wr(8'h31, mask[7:0]);
			wr(8'h32, mask[15:8]);
			wr(8'h0b, op);
			wr(8'h0f, 8'(x[19:17]));
			cyc(900);
			old = exp_flags(t_prev & en, g);
			rd(8'h65, d);
			check(16'(d), 16'(old[15:8]));
			rd(8'h66, d);
			check(16'(d), 16'(old[7:0]));
			check(16'(pin_n), 16'h0001);
			for (int k = 0; k < 16; k++) level[16*k+:16] = t[k] ? 16'h0040 : 16'h0010;
			cyc(900);
			f = exp_flags(t & en, g);
			check(16'(pin_n), 16'(op != 8'h00 || ((f ^ old) & mask) == 16'h0));
			rd(8'h65, d);
			check(16'(d), 16'(f[15:8]));
			rd(8'h66, d);
			check(16'(d), 16'(f[7:0]));
			for (int k = 0; k < 16; k++) begin
				if (en[k]) begin
					rd(8'h43 + 8'(2 * k), d);
					rd(8'h44 + 8'(2 * k), e);
					check({d, e}, level[16*k+:16] + 16'h1000);
				end
			end
			// Position is held after release, so only judge it with a slider key down
			for (int k = 0; k < 16; k++) sl[k] = (g[2*k+:2] == 2'b11);
			if (en == 16'hffff && (t & sl) != 16'h0) begin
				rd(8'h64, d);
				check(16'(d), 16'(exp_pos(t, g)));
			end
			t_prev = t;
		end
		wr(8'h1f, 8'h00);
		wr(8'h63, 8'h00);
		clear_n = 1'b0;
		cyc(5);
		clear_n = 1'b1;
		cyc(6);
		rd(8'h1f, d);
		check(16'(d), 16'h00ff);
		rd(8'h63, d);
		check(16'(d), 16'h0001);
		give_verdict();
	end
endmodule
bind tkrr_touch_key_regs tkrr_regs_checker i_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
	.master_clear_reset_n_i(master_clear_reset_n_i), .watchdog_event_i(watchdog_event_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .meas_req_o(meas_req_o),
	.meas_key_o(meas_key_o), .meas_done_i(meas_done_i), .meas_raw_i(meas_raw_i),
	.meas_delta_i(meas_delta_i), .ready_request_low_o(ready_request_low_o));
